// File: common/alu_pkg.sv
`default_nettype none
package alu_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses on APB)
    // ------------------------------------------------------------
    localparam logic [11:0] status_word_addr   = 12'h0d0;
    localparam logic [11:0] operand_addr       = 12'h0e0;
    localparam logic [11:0] aux_addr           = 12'h0f0;
    localparam logic [11:0] op_ctrl_addr       = 12'h100;
    localparam logic [11:0] result_addr        = 12'h104;
    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int          carry_bit          = 7;
    localparam int          half_carry_bit     = 6;
    localparam int          user_bit           = 5;
    localparam int          bank_high_bit      = 4;
    localparam int          bank_low_bit       = 3;
    localparam int          overflow_bit       = 2;
    localparam int          parity_bit         = 0;
    localparam logic [7:0]  status_reset       = 8'h00;
    localparam logic [7:0]  status_write_mask  = 8'hfc;
    localparam logic [7:0]  byte_reset         = 8'h00;
    localparam logic [4:0]  bank_stride        = 5'h08;
    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        op_add  = 4'h0,
        op_addc = 4'h1,
        op_subb = 4'h2,
        op_mul  = 4'h3,
        op_div  = 4'h4,
        op_and  = 4'h5,
        op_or   = 4'h6,
        op_xor  = 4'h7,
        op_rl   = 4'h8,
        op_rr   = 4'h9,
        op_rlc  = 4'ha,
        op_rrc  = 4'hb,
        op_cpl  = 4'hc,
        op_bset = 4'hd,
        op_bclr = 4'he,
        op_bcpl = 4'hf
    } alu_op_t;
endpackage
`default_nettype wire

// File: rtl/alu_engine.sv
`default_nettype none
module alu_engine (
    // Operands
    input  wire logic           [7:0] a,
    input  wire logic           [7:0] b,
    input  wire logic                 cin,
    input  wire alu_pkg::alu_op_t     op,
    // Results
    output logic                [7:0] res,
    output logic                [7:0] res_hi,
    output logic                      cout,
    output logic                      hcout,
    output logic                      ovf,
    output logic                      arith,
    output logic                      mul_div
);
    import alu_pkg::*;

    logic [8:0] sum;
    logic [4:0] nib;
    logic [15:0] prod;

    always_comb begin
        sum     = 9'h000;
        nib     = 5'h00;
        prod    = {8'h00, a} * {8'h00, b};
        res     = a;
        res_hi  = b;
        cout    = cin;
        hcout   = 1'b0;
        ovf     = 1'b0;
        arith   = 1'b0;
        mul_div = 1'b0;
        case (op)
            op_add, op_addc: begin
                sum   = {1'b0, a} + {1'b0, b} + {8'h00, (op == op_addc) & cin};
                nib   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, (op == op_addc) & cin};
                res   = sum[7:0];
                cout  = sum[8];
                hcout = nib[4];
                ovf   = (a[7] == b[7]) && (sum[7] != a[7]);
                arith = 1'b1;
            end
            op_subb: begin
                sum   = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                nib   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
                res   = sum[7:0];
                cout  = sum[8];
                hcout = nib[4];
                ovf   = (a[7] != b[7]) && (sum[7] != a[7]);
                arith = 1'b1;
            end
            op_mul: begin
                res     = prod[7:0];
                res_hi  = prod[15:8];
                cout    = 1'b0;
                ovf     = |prod[15:8];
                mul_div = 1'b1;
            end
            op_div: begin
                // Divide by zero leaves operands alone and flags overflow
                mul_div = 1'b1;
                cout    = 1'b0;
                if (b == 8'h00) begin
                    ovf = 1'b1;
                end else begin
                    res    = a / b;
                    res_hi = a % b;
                end
            end
            op_and:  res = a & b;
            op_or:   res = a | b;
            op_xor:  res = a ^ b;
            op_rl:   res = {a[6:0], a[7]};
            op_rr:   res = {a[0], a[7:1]};
            op_rlc: begin
                res  = {a[6:0], cin};
                cout = a[7];
            end
            op_rrc: begin
                res  = {cin, a[7:1]};
                cout = a[0];
            end
            op_cpl:  res = ~a;
            op_bset: res = a | (8'h01 << b[2:0]);
            op_bclr: res = a & ~(8'h01 << b[2:0]);
            op_bcpl: res = a ^ (8'h01 << b[2:0]);
            default: res = a;
        endcase
    end
endmodule
`default_nettype wire

// File: rtl/alu_status_word_flags.sv
// Our own choice: the APB interface to the registers.
`default_nettype none
module alu_status_word_flags (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Working register bank
    output logic      [4:0]  bank_base
);
    import alu_pkg::*;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic       acc_wr;
    logic       aux_wr;
    logic       wr_en;
    logic       rd_setup;
    logic       mapped;
    logic [7:0] status_q;
    logic [7:0] work_operand_reg_q;
    logic [7:0] aux_q;
    logic [7:0] res;
    logic [7:0] res_hi;
    logic       cout;
    logic       hcout;
    logic       ovf;
    logic       arith;
    logic       mul_div;
    logic       op_go;
    alu_op_t    op;

    function automatic logic hit(input logic [11:0] a);
        hit = (paddr == a);
    endfunction

    assign wr_en   = psel && penable && pwrite && pstrb[0];
    assign rd_setup = psel && !penable && !pwrite;
    assign mapped  = hit(status_word_addr) || hit(operand_addr) || hit(aux_addr)
                     || hit(op_ctrl_addr) || hit(result_addr);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign acc_wr  = wr_en && hit(operand_addr);
    assign aux_wr  = wr_en && hit(aux_addr);
    // Writing the control word launches one operation in that cycle
    assign op_go   = wr_en && hit(op_ctrl_addr);
    assign op      = alu_op_t'(pwdata[3:0]);

    // ------------------------------------------------------------
    // Arithmetic engine
    // ------------------------------------------------------------
    alu_engine u_engine (
        .a       (work_operand_reg_q),
        .b       (aux_q),
        .cin     (status_q[carry_bit]),
        .op      (op),
        .res     (res),
        .res_hi  (res_hi),
        .cout    (cout),
        .hcout   (hcout),
        .ovf     (ovf),
        .arith   (arith),
        .mul_div (mul_div)
    );

    // ------------------------------------------------------------
    // Accumulator and auxiliary register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            work_operand_reg_q <= byte_reset;
        end else if (op_go) begin
            work_operand_reg_q <= res;
        end else if (acc_wr) begin
            work_operand_reg_q <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            aux_q <= byte_reset;
        end else if (op_go && mul_div) begin
            aux_q <= res_hi;
        end else if (aux_wr) begin
            aux_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    // Operation writes win over a software write in the same cycle;
    // both cannot happen since each needs its own APB access.
    always_ff @(posedge clock) begin
        if (srst) begin
            status_q <= status_reset;
        end else if (op_go) begin
            status_q[carry_bit] <= cout;
            if (arith) begin
                status_q[half_carry_bit] <= hcout;
            end
            if (arith || mul_div) begin
                status_q[overflow_bit] <= ovf;
            end
        end else if (wr_en && hit(status_word_addr)) begin
            // User and bank bits only move here
            status_q[7:2] <= pwdata[7:2];
        end
    end

    // Parity is combinational from the accumulator, never stale
    logic [7:0] status_view;
    always_comb begin
        status_view             = status_q & status_write_mask;
        status_view[parity_bit] = ^work_operand_reg_q;
    end

    assign bank_base = {status_q[bank_high_bit], status_q[bank_low_bit], 3'b000};

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            // Captured in setup so the access phase needs no wait state
            if (paddr == status_word_addr) begin
                prdata <= {24'h000000, status_view};
            end else if (paddr == operand_addr || paddr == result_addr) begin
                prdata <= {24'h000000, work_operand_reg_q};
            end else if (paddr == aux_addr) begin
                prdata <= {24'h000000, aux_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

endmodule
`default_nettype wire

// File: tb/alu_status_word_flags_sva.sv
`default_nettype none
module alu_status_word_flags_sva (
    // Clock and reset
    input wire logic        clock,
    input wire logic        srst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Bank
    input wire logic [4:0]  bank_base
);
    timeunit 1ns;
    timeprecision 100ps;
    import alu_pkg::*;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    logic       acc_ph;
    logic       mapped;
    logic       st_wr;
    logic [1:0] wr_bank;
    assign acc_ph = psel && penable;
    assign mapped = paddr inside {status_word_addr, operand_addr, aux_addr, op_ctrl_addr, result_addr};
    assign st_wr = acc_ph && pwrite && pstrb[0] && paddr == status_word_addr;
    assign wr_bank = pwdata[4:3];
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_ready_high: assert property (acc_ph |-> pready) else $error("pready low in access");
    chk_bank_write: assert property (st_wr |=> bank_base == {$past(wr_bank), 3'h0})
        else $error("bank base wrong after write");
    chk_bank_only_sw: assert property ($changed(bank_base) |-> $past(st_wr))
        else $error("bank base moved without write");
    chk_reset_clear: assert property ($past(srst) |-> bank_base == 5'h00 && prdata == 32'h0)
        else $error("state not cleared by reset");
    chk_bit1_zero: assert property (acc_ph && !pwrite && paddr == status_word_addr |-> !prdata[1])
        else $error("status bit 1 not zero");
    chk_upper_zero: assert property (acc_ph && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_err_unmapped: assert property (acc_ph && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_err_only: assert property (pslverr |-> acc_ph && !mapped)
        else $error("spurious slave error");
endmodule
bind alu_status_word_flags alu_status_word_flags_sva chk (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bank_base(bank_base));
`default_nettype wire

// File: tb/seq_model.sv
`default_nettype none
module seq_model (
    // Clock
    input  wire logic        clock,
    // APB master
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    output var  logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = 51'h0;
    // ----------------------------------------
    // One transfer, held until pready
    // ----------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v,
                        input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, v, s};
        @(posedge clock);
        penable <= 1'b1;
        // No cycle limit: only the bench watchdog ends a stalled wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // Released lines must not keep looking valid
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~v};
    endtask
endmodule
`default_nettype wire

// File: tb/alu_status_word_flags_tb.sv
`default_nettype none
module alu_status_word_flags_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import alu_pkg::*;
    logic        clock, srst, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0]  pstrb;
    logic [4:0]  bank_base;
    int          fails, samples_checked;
    alu_status_word_flags dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bank_base(bank_base));
    seq_model seq (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] x;
        logic        er;
        seq.xfer(1'b1, a, v, 4'hf, x, er);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        logic er;
        seq.xfer(1'b0, a, 32'h0, 4'h0, v, er);
    endtask
    // Half carry is left out of the mask for mul and div; only add and subtract define it
    task automatic run(input logic [7:0] pre, input alu_op_t op, input logic [7:0] a, input logic [7:0] b,
                       input logic [7:0] er, input logic [7:0] eb, input logic [7:0] es, input logic [7:0] m);
        wr(status_word_addr, {24'h0, pre});
        wr(operand_addr, {24'h0, a});
        wr(aux_addr, {24'h0, b});
        wr(op_ctrl_addr, {28'h0, op});
        rd(result_addr, d);
        chk("result", d, {24'h0, er});
        rd(aux_addr, d);
        chk("aux", d, {24'h0, eb});
        rd(status_word_addr, d);
        chk("status", d & {24'h0, m}, {24'h0, es & m});
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clock);
        fails++;
        give_verdict;
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        fails = 0;
        samples_checked = 0;
        srst = 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(status_word_addr, d);
        chk("status_rst", d, 32'h0);
        wr(status_word_addr, 32'hff);
        rd(status_word_addr, d);
        chk("status_rw", d, 32'hfc);
        for (int i = 0; i < 4; i++) begin
            wr(status_word_addr, 32'(i * 8));
            rd(status_word_addr, d);
            chk("bank", {27'h0, bank_base}, 32'(i * 8));
        end
        seq.xfer(1'b1, status_word_addr, 32'h0, 4'h0, d, e);
        rd(status_word_addr, d);
        chk("strb_off", d, 32'h18);
        seq.xfer(1'b0, 12'h0d4, 32'h0, 4'h0, d, e);
        chk("unmapped", {e, d[30:0]}, 32'h80000000);
        run(8'h20, op_add, 8'hff, 8'h01, 8'h00, 8'h01, 8'he0, 8'hff);
        run(8'h20, op_add, 8'h7f, 8'h01, 8'h80, 8'h01, 8'h65, 8'hff);
        run(8'ha0, op_addc, 8'h0e, 8'h01, 8'h10, 8'h01, 8'h61, 8'hff);
        run(8'h20, op_subb, 8'h80, 8'h01, 8'h7f, 8'h01, 8'h65, 8'hff);
        run(8'ha0, op_subb, 8'h00, 8'h00, 8'hff, 8'h00, 8'he0, 8'hff);
        run(8'h20, op_mul, 8'h10, 8'h20, 8'h00, 8'h02, 8'h24, 8'hbf);
        run(8'h20, op_div, 8'h64, 8'h07, 8'h0e, 8'h02, 8'h21, 8'hbf);
        run(8'h20, op_div, 8'h05, 8'h00, 8'h05, 8'h00, 8'h24, 8'hbf);
        run(8'ha0, op_rlc, 8'h80, 8'h00, 8'h01, 8'h00, 8'ha1, 8'hff);
        run(8'h20, op_rrc, 8'h01, 8'h00, 8'h00, 8'h00, 8'ha0, 8'hff);
        run(8'h20, op_rl, 8'h81, 8'h00, 8'h03, 8'h00, 8'h20, 8'hff);
        run(8'h20, op_rr, 8'h01, 8'h00, 8'h80, 8'h00, 8'h21, 8'hff);
        run(8'h20, op_and, 8'hf0, 8'h3c, 8'h30, 8'h3c, 8'h20, 8'hff);
        run(8'he4, op_or, 8'h0f, 8'h10, 8'h1f, 8'h10, 8'he5, 8'hff);
        run(8'h20, op_xor, 8'hff, 8'h0f, 8'hf0, 8'h0f, 8'h20, 8'hff);
        run(8'h20, op_cpl, 8'h0f, 8'h00, 8'hf0, 8'h00, 8'h20, 8'hff);
        run(8'h20, op_bclr, 8'hff, 8'h07, 8'h7f, 8'h07, 8'h21, 8'hff);
        run(8'h20, op_bcpl, 8'h55, 8'h02, 8'h51, 8'h02, 8'h21, 8'hff);
        run(8'h20, op_bset, 8'h00, 8'h03, 8'h08, 8'h03, 8'h21, 8'hff);
        wr(operand_addr, 32'h07);
        rd(status_word_addr, d);
        chk("parity", d & 32'h1, 32'h1);
        // Second reset with live bank, parity and accumulator
        wr(status_word_addr, 32'h18);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        rd(status_word_addr, d);
        chk("status_rst2", d, 32'h0);
        rd(operand_addr, d);
        chk("acc_rst2", d, 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
